// *** verilog/mssd_pkg.sv ***
// Constants shared by the data-side core: offsets, fields, reset values and operation codes.
package mssd_pkg;
	localparam int STACK_LEVELS = 8;
	localparam logic [3:0] STACK_FULL = 4'h8;
	localparam logic [2:0] SP_RESET = 3'h0;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int GP_BYTES = 192;

	localparam logic [7:0] ADDR_IND_A = 8'h00;
	localparam logic [7:0] ADDR_MP_A = 8'h01;
	localparam logic [7:0] ADDR_IND_B = 8'h02;
	localparam logic [7:0] ADDR_MP_B = 8'h03;
	localparam logic [7:0] ADDR_ACC = 8'h05;
	localparam logic [7:0] ADDR_PCL = 8'h06;
	localparam logic [7:0] ADDR_LOOKUP_POINTER = 8'h07;
	localparam logic [7:0] ADDR_LOOKUP_HIGH_BYTE = 8'h08;
	localparam logic [7:0] ADDR_WDT_OPT = 8'h09;
	localparam logic [7:0] ADDR_FLAGS = 8'h0a;
	localparam logic [7:0] ADDR_IRQ = 8'h0b;
	localparam logic [7:0] ADDR_SFR_LAST = 8'h15;
	localparam logic [7:0] ADDR_ROM_BANK = 8'h1c;
	localparam logic [7:0] ADDR_SYNTH_FIRST = 8'h20;
	localparam logic [7:0] ADDR_SYNTH_LAST = 8'h2a;
	localparam logic [7:0] ADDR_GP_FIRST = 8'h40;

	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_PD = 4;
	localparam int FLAG_TO = 5;
	localparam int IRQ_GLOBAL = 0;
	localparam int IRQ_EN0 = 2;
	localparam int IRQ_EN1 = 3;
	localparam int IRQ_REQ0 = 5;
	localparam int IRQ_REQ1 = 6;

	localparam logic [12:0] VEC_TIMER0 = 13'h0008;
	localparam logic [12:0] VEC_TIMER1 = 13'h000c;

	typedef enum logic [4:0] {
		OP_READ = 5'h00, OP_WRITE = 5'h01, OP_LOADI = 5'h02, OP_ADD = 5'h03,
		OP_ADC = 5'h04, OP_SUB = 5'h05, OP_SBC = 5'h06, OP_DAA = 5'h07,
		OP_AND = 5'h08, OP_OR = 5'h09, OP_XOR = 5'h0a, OP_CPL = 5'h0b,
		OP_RL = 5'h0c, OP_RR = 5'h0d, OP_RLC = 5'h0e, OP_RRC = 5'h0f,
		OP_INC = 5'h10, OP_DEC = 5'h11, OP_SZ = 5'h12, OP_SIZ = 5'h13,
		OP_SDZ = 5'h14, OP_SETB = 5'h15, OP_CLRB = 5'h16, OP_SNZB = 5'h17
	} mssd_op_t;
endpackage

// *** verilog/mssd_core.sv ***
// Data-side core: return stack, data memory map, accumulator, ALU, flags and interrupt gating.
// Operation
// - Eight-level stack holds program counter values only; software cannot reach it.
// - Call or interrupt acknowledge pushes the counter; either return pops it.
// - Reset points the stack index at the empty top position.
// - Full stack latches an enabled request but withholds acknowledge until a return.
// - Call on a full stack overwrites the oldest entry.
// - Two data banks; general storage at 40H to FFH, 192 bytes each.
// - Synthesizer registers at 20H to 2AH; unassigned locations below 30H read 00H.
// - Address 00H goes through pointer A, address 02H through pointer B.
// - Direct access of an indirect location reads 00H and writes nothing.
// - Accumulator at 05H takes immediates; memory moves pass through it.
// - Every assigned location except the lookup high byte at 08H, which ignores writes, supports ALU operations and single-bit set and clear.
// - ALU does add, subtract, adjust, logic, rotate, step and skip tests.
// - Carry in bit 0 is add carry-out or no borrow; rotate-through-carry updates it.
// - Half carry in bit 1 follows the low nibble carry or no borrow.
// - Zero flag in bit 2 marks a zero result.
// - Overflow in bit 3 is carry into bit 7 differing from carry out.
// - Power-down flag cleared by power-up or watchdog clear, set by halt.
// - Expiry flag cleared by power-up, watchdog clear or halt, set by time-out.
// - Software writes to the flags leave expiry and power-down flags alone.
// - Flag bits 6 and 7 always read zero.
// - Acknowledge clears the global enable; later requests only set their flags.
// - Return from interrupt sets the global enable; plain return leaves it.
// - Interrupt control: bit 0 global, bits 2,3 enables, bits 5,6 requests.
`timescale 1ns/1ps
module mssd_core
	import mssd_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Execute port from the sequencer.
	input wire logic exec_valid_i,
	input wire logic [4:0] op_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] imm_i,
	input wire logic use_imm_i,
	input wire logic to_acc_i,
	input wire logic [2:0] bit_i,
	input wire logic data_bank_i,
	// Control transfer.
	input wire logic call_i,
	input wire logic return_from_sub_i,
	input wire logic return_from_irq_i,
	input wire logic [12:0] pc_i,
	// System events.
	input wire logic halt_i,
	input wire logic watchdog_clear_instr_i,
	input wire logic watchdog_timeout_i,
	input wire logic timer0_ovf_i,
	input wire logic timer1_ovf_i,
	// Results.
	output logic [7:0] rdata_o,
	output logic skip_o,
	output logic [12:0] ret_pc_o,
	output logic irq_ack_o,
	output logic [12:0] irq_vec_o,
	output logic [7:0] working_accumulator_o
);
	typedef struct packed {
		logic [1:0][GP_BYTES-1:0][7:0] ram;
		logic [31:0][7:0] sfr;
		logic [10:0][7:0] synth;
		logic [7:0] memory_pointer_a;
		logic [7:0] memory_pointer_b;
		logic [7:0] working_accumulator;
		logic carry_flag;
		logic half_carry_flag;
		logic zero_flag;
		logic signed_overflow_flag;
		logic powerdown_flag;
		logic watchdog_expired_flag;
		logic global_irq_enable;
		logic irq_en0;
		logic irq_en1;
		logic irq_req0;
		logic irq_req1;
		logic [STACK_LEVELS-1:0][12:0] stack;
		logic [2:0] return_stack_index;
		logic [3:0] depth;
		logic [12:0] ret_pc;
		logic [7:0] rdata;
		logic skip;
		logic ack;
		logic [12:0] vec;
	} mssd_state_t;

	localparam mssd_state_t ST_RESET = '0;

	mssd_state_t q;
	mssd_state_t d;

	// Resolves the indirect locations through their pointers.
	function automatic logic [7:0] eff_addr(input mssd_state_t s, input logic [7:0] a);
		if (a == ADDR_IND_A) begin
			return s.memory_pointer_a;
		end else if (a == ADDR_IND_B) begin
			return s.memory_pointer_b;
		end
		return a;
	endfunction

	function automatic logic is_plain_sfr(input logic [7:0] a);
		return (a >= ADDR_PCL && a <= ADDR_SFR_LAST && a != ADDR_FLAGS && a != ADDR_IRQ) || a == ADDR_ROM_BANK;
	endfunction

	function automatic logic [7:0] rd_byte(input mssd_state_t s, input logic [7:0] a, input logic bank);
		logic [7:0] idx;
		idx = a - ADDR_GP_FIRST;
		if (a >= ADDR_GP_FIRST) begin
			return s.ram[bank][idx];
		end else if (a == ADDR_MP_A) begin
			return s.memory_pointer_a;
		end else if (a == ADDR_MP_B) begin
			return s.memory_pointer_b;
		end else if (a == ADDR_ACC) begin
			return s.working_accumulator;
		end else if (a == ADDR_FLAGS) begin
			return {2'h0, s.watchdog_expired_flag, s.powerdown_flag, s.signed_overflow_flag, s.zero_flag,
				s.half_carry_flag, s.carry_flag};
		end else if (a == ADDR_IRQ) begin
			return {1'b0, s.irq_req1, s.irq_req0, 1'b0, s.irq_en1, s.irq_en0, 1'b0, s.global_irq_enable};
		end else if (is_plain_sfr(a)) begin
			return s.sfr[a[4:0]];
		end else if (a >= ADDR_SYNTH_FIRST && a <= ADDR_SYNTH_LAST) begin
			return s.synth[4'(a - ADDR_SYNTH_FIRST)];
		end
		return BYTE_ZERO;
	endfunction

	logic [7:0] ea;
	logic [7:0] opb;
	logic [7:0] addy;
	logic addc;
	logic [8:0] sum9;
	logic [4:0] lo5;
	logic [7:0] lo8;
	logic [8:0] daa9;
	logic [7:0] res;
	logic wr_acc;
	logic wr_mem;
	logic arith;
	logic logic_z;
	logic [12:0] pop_val;
	logic irq_want;
	logic busy_xfer;

	always_comb begin
		d = q;
		d.ack = 1'b0;
		d.skip = 1'b0;
		ea = eff_addr(q, addr_i);
		opb = use_imm_i ? imm_i : rd_byte(q, ea, data_bank_i);
		addy = (op_i == OP_SUB || op_i == OP_SBC) ? ~opb : opb;
		addc = (op_i == OP_ADD) ? 1'b0 : (op_i == OP_SUB) ? 1'b1 : q.carry_flag;
		sum9 = {1'b0, q.working_accumulator} + {1'b0, addy} + {8'h00, addc};
		lo5 = {1'b0, q.working_accumulator[3:0]} + {1'b0, addy[3:0]} + {4'h0, addc};
		lo8 = {1'b0, q.working_accumulator[6:0]} + {1'b0, addy[6:0]} + {7'h00, addc};
		daa9 = {1'b0, q.working_accumulator};
		if (q.working_accumulator[3:0] > 4'h9 || q.half_carry_flag) begin
			daa9 = daa9 + 9'h006;
		end
		if (daa9[8:4] > 5'h09 || q.carry_flag) begin
			daa9 = daa9 + 9'h060;
		end
		res = BYTE_ZERO;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		arith = 1'b0;
		logic_z = 1'b0;
		pop_val = q.stack[3'(q.return_stack_index - 3'h1)];
		if (exec_valid_i) begin
			unique case (op_i)
				OP_READ: begin
					res = opb;
					wr_acc = to_acc_i;
				end
				OP_WRITE: begin
					res = q.working_accumulator;
					wr_mem = 1'b1;
				end
				OP_LOADI: begin
					res = imm_i;
					wr_acc = 1'b1;
				end
				OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
					res = sum9[7:0];
					arith = 1'b1;
				end
				OP_DAA: begin
					res = daa9[7:0];
					d.carry_flag = daa9[8] | q.carry_flag;
				end
				OP_AND, OP_OR, OP_XOR: begin
					res = (op_i == OP_AND) ? (q.working_accumulator & opb) :
						(op_i == OP_OR) ? (q.working_accumulator | opb) : (q.working_accumulator ^ opb);
					logic_z = 1'b1;
				end
				OP_CPL, OP_INC, OP_DEC: begin
					res = (op_i == OP_CPL) ? ~opb : (op_i == OP_INC) ? opb + 8'h01 : opb - 8'h01;
					logic_z = 1'b1;
				end
				OP_RL, OP_RR: begin
					res = (op_i == OP_RL) ? {opb[6:0], opb[7]} : {opb[0], opb[7:1]};
				end
				OP_RLC: begin
					res = {opb[6:0], q.carry_flag};
					d.carry_flag = opb[7];
				end
				OP_RRC: begin
					res = {q.carry_flag, opb[7:1]};
					d.carry_flag = opb[0];
				end
				OP_SZ: begin
					res = opb;
					d.skip = (opb == BYTE_ZERO);
				end
				OP_SIZ, OP_SDZ: begin
					res = (op_i == OP_SIZ) ? opb + 8'h01 : opb - 8'h01;
					d.skip = (res == BYTE_ZERO);
				end
				OP_SETB, OP_CLRB: begin
					res = opb;
					res[bit_i] = (op_i == OP_SETB);
					wr_mem = 1'b1;
				end
				OP_SNZB: begin
					res = opb;
					d.skip = opb[bit_i];
				end
				default: begin
					res = BYTE_ZERO;
				end
			endcase
			if (op_i != OP_READ && op_i != OP_WRITE && op_i != OP_LOADI && op_i != OP_SETB &&
				op_i != OP_CLRB && op_i != OP_SNZB && op_i != OP_SZ) begin
				wr_acc = to_acc_i;
				wr_mem = !to_acc_i;
			end
			d.rdata = res;
		end
		if (arith) begin
			d.carry_flag = sum9[8];
			d.half_carry_flag = lo5[4];
			d.signed_overflow_flag = lo8[7] ^ sum9[8];
		end
		if (arith || logic_z) begin
			d.zero_flag = (res == BYTE_ZERO);
		end
		if (wr_acc) begin
			d.working_accumulator = res;
		end else if (wr_mem) begin
			if (ea >= ADDR_GP_FIRST) begin
				d.ram[data_bank_i][8'(ea - ADDR_GP_FIRST)] = res;
			end else if (ea == ADDR_MP_A) begin
				d.memory_pointer_a = res;
			end else if (ea == ADDR_MP_B) begin
				d.memory_pointer_b = res;
			end else if (ea == ADDR_ACC) begin
				d.working_accumulator = res;
			end else if (ea == ADDR_FLAGS) begin
				d.carry_flag = res[FLAG_C];
				d.half_carry_flag = res[FLAG_AC];
				d.zero_flag = res[FLAG_Z];
				d.signed_overflow_flag = res[FLAG_OV];
			end else if (ea == ADDR_IRQ) begin
				d.global_irq_enable = res[IRQ_GLOBAL];
				d.irq_en0 = res[IRQ_EN0];
				d.irq_en1 = res[IRQ_EN1];
				d.irq_req0 = res[IRQ_REQ0];
				d.irq_req1 = res[IRQ_REQ1];
			end else if (is_plain_sfr(ea) && ea != ADDR_LOOKUP_HIGH_BYTE) begin
				d.sfr[ea[4:0]] = res;
			end else if (ea >= ADDR_SYNTH_FIRST && ea <= ADDR_SYNTH_LAST) begin
				d.synth[4'(ea - ADDR_SYNTH_FIRST)] = res;
			end
		end
		busy_xfer = call_i || return_from_sub_i || return_from_irq_i;
		irq_want = q.global_irq_enable && ((q.irq_en0 && q.irq_req0) || (q.irq_en1 && q.irq_req1));
		if (call_i) begin
			d.stack[q.return_stack_index] = pc_i;
			d.return_stack_index = q.return_stack_index + 3'h1;
			d.depth = (q.depth == STACK_FULL) ? STACK_FULL : q.depth + 4'h1;
		end else if (return_from_sub_i || return_from_irq_i) begin
			d.ret_pc = pop_val;
			d.return_stack_index = q.return_stack_index - 3'h1;
			d.depth = (q.depth == 4'h0) ? 4'h0 : q.depth - 4'h1;
			if (return_from_irq_i) begin
				d.global_irq_enable = 1'b1;
			end
		end else if (irq_want && q.depth != STACK_FULL) begin
			d.stack[q.return_stack_index] = pc_i;
			d.return_stack_index = q.return_stack_index + 3'h1;
			d.depth = q.depth + 4'h1;
			d.global_irq_enable = 1'b0;
			d.ack = 1'b1;
			if (q.irq_en0 && q.irq_req0) begin
				d.irq_req0 = 1'b0;
				d.vec = VEC_TIMER0;
			end else begin
				d.irq_req1 = 1'b0;
				d.vec = VEC_TIMER1;
			end
		end
		if (timer0_ovf_i) begin
			d.irq_req0 = 1'b1;
		end
		if (timer1_ovf_i) begin
			d.irq_req1 = 1'b1;
		end
		if (halt_i) begin
			d.powerdown_flag = 1'b1;
			d.watchdog_expired_flag = 1'b0;
		end
		if (watchdog_clear_instr_i) begin
			d.powerdown_flag = 1'b0;
			d.watchdog_expired_flag = 1'b0;
		end
		if (watchdog_timeout_i) begin
			d.watchdog_expired_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			q <= ST_RESET;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign skip_o = q.skip;
	assign ret_pc_o = q.ret_pc;
	assign irq_ack_o = q.ack;
	assign irq_vec_o = q.vec;
	assign working_accumulator_o = q.working_accumulator;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_reset_release;
		$rose(rst_n_i);
	endsequence

	sequence s_pending_full;
		irq_want && q.depth == STACK_FULL && !busy_xfer;
	endsequence

	chk_reset_top: assert property (@(posedge clk_i) s_reset_release |-> q.return_stack_index == SP_RESET
		&& q.depth == 4'h0) else $error("stack index not at top after reset");
	chk_full_withhold: assert property (s_pending_full |=> !irq_ack_o && q.global_irq_enable)
		else $error("acknowledge given with full stack");
	chk_ret_then_ack: assert property (s_pending_full ##1 (return_from_sub_i && !call_i && !timer0_ovf_i
		&& !timer1_ovf_i && !exec_valid_i) ##1 (!busy_xfer && !exec_valid_i) |=> irq_ack_o)
		else $error("pending request not served after return");
	chk_ack_masks: assert property (irq_ack_o |-> !q.global_irq_enable && q.depth != 4'h0)
		else $error("acknowledge left global enable set");
	chk_return_from_irq_enable: assert property (return_from_irq_i && !call_i |=> q.global_irq_enable)
		else $error("return from interrupt did not enable");
	chk_call_ret_pair: assert property (call_i ##1 (return_from_sub_i && !call_i) |=> ret_pc_o == $past(pc_i, 2))
		else $error("pop did not return last pushed counter");
	chk_flags_upper: assert property (exec_valid_i && op_i == OP_READ && addr_i == ADDR_FLAGS && !use_imm_i
		|=> rdata_o[7:6] == 2'h0 && rdata_o[5] == $past(q.watchdog_expired_flag))
		else $error("flag read shows wrong upper bits");
	chk_indirect_direct: assert property (exec_valid_i && op_i == OP_READ && !use_imm_i && addr_i == ADDR_IND_B
		&& (q.memory_pointer_b == ADDR_IND_A || q.memory_pointer_b == ADDR_IND_B) |=> rdata_o == BYTE_ZERO)
		else $error("indirect location read not zero");
	chk_halt_flags: assert property (halt_i && !watchdog_clear_instr_i && !watchdog_timeout_i
		|=> q.powerdown_flag && !q.watchdog_expired_flag) else $error("halt did not update flags");
	chk_flags_write: assert property (exec_valid_i && op_i == OP_WRITE && addr_i == ADDR_FLAGS && !halt_i
		&& !watchdog_clear_instr_i && !watchdog_timeout_i
		|=> $stable(q.powerdown_flag) && $stable(q.watchdog_expired_flag))
		else $error("flag write changed protected flags");
	chk_add_carry: assert property (exec_valid_i && op_i == OP_ADD && to_acc_i
		|=> q.carry_flag == $past(sum9[8]) && q.zero_flag == (q.working_accumulator == BYTE_ZERO))
		else $error("add flags wrong");
endmodule

// *** test/mssd_seq_model.sv ***
// Behavioural sequencer that supplies the program counter and follows interrupt vectors.
`timescale 1ns/1ps
module mssd_seq_model
	import mssd_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Jump requests from the program.
	input wire logic load_i,
	input wire logic [12:0] load_pc_i,
	// Core answers.
	input wire logic irq_ack_i,
	input wire logic [12:0] irq_vec_i,
	// Counter shown to the core.
	output logic [12:0] pc_o
);
	logic [12:0] pc_q;
	// A jump shows its target at once, so a call in the same cycle pushes that target.
	assign pc_o = load_i ? load_pc_i : pc_q;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_q <= PC_RESET;
		end else if (irq_ack_i) begin
			pc_q <= irq_vec_i;
		end else if (load_i) begin
			pc_q <= load_pc_i;
		end
	end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the data-side core driven through a behavioural sequencer.
`timescale 1ns/1ps
module tb;
	import mssd_pkg::*;
	typedef struct {mssd_op_t op; logic [7:0] a; logic [7:0] im; logic ui; logic ta; logic [2:0] b;
		logic ck; logic [7:0] ex; logic sk;} mssd_row_t;
	logic clk_i = 0, rst_n_i = 0, exec_valid_i = 0, use_imm_i = 0, to_acc_i = 0, data_bank_i = 0;
	logic call_i = 0, return_from_sub_i = 0, return_from_irq_i = 0, halt_i = 0, load_q = 0;
	logic watchdog_clear_instr_i = 0, watchdog_timeout_i = 0, timer0_ovf_i = 0, timer1_ovf_i = 0;
	logic [4:0] op_i = 5'h00;
	logic [7:0] addr_i = 8'h00, imm_i = 8'h00, rdata_o, working_accumulator_o;
	logic [2:0] bit_i = 3'h0;
	logic [12:0] load_pc_q = 13'h0000, pc_i, ret_pc_o, irq_vec_o;
	logic skip_o, irq_ack_o;
	int error_cnt = 0, checks = 0;
	mssd_row_t rows[51] = '{
		'{OP_LOADI, 8'h00, 8'h7f, 1, 1, 0, 1, 8'h7f, 0}, '{OP_WRITE, 8'h40, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_LOADI, 8'h00, 8'h01, 1, 1, 0, 1, 8'h01, 0}, '{OP_ADD, 8'h40, 8'h00, 0, 1, 0, 1, 8'h80, 0},
		'{OP_READ, 8'h0a, 8'h00, 0, 0, 0, 1, 8'h0a, 0}, '{OP_LOADI, 8'h00, 8'hff, 1, 1, 0, 1, 8'hff, 0},
		'{OP_ADD, 8'h00, 8'h01, 1, 1, 0, 1, 8'h00, 0}, '{OP_READ, 8'h0a, 8'h00, 0, 0, 0, 1, 8'h07, 0},
		'{OP_LOADI, 8'h00, 8'h05, 1, 1, 0, 1, 8'h05, 0}, '{OP_SUB, 8'h00, 8'h03, 1, 1, 0, 1, 8'h02, 0},
		'{OP_READ, 8'h0a, 8'h00, 0, 0, 0, 1, 8'h03, 0}, '{OP_ADC, 8'h00, 8'h01, 1, 1, 0, 1, 8'h04, 0},
		'{OP_SBC, 8'h00, 8'h01, 1, 1, 0, 1, 8'h02, 0}, '{OP_READ, 8'h0a, 8'h00, 0, 0, 0, 1, 8'h03, 0},
		'{OP_INC, 8'h40, 8'h00, 0, 1, 0, 1, 8'h80, 0}, '{OP_DEC, 8'h40, 8'h00, 0, 1, 0, 1, 8'h7e, 0},
		'{OP_RL, 8'h40, 8'h00, 0, 1, 0, 1, 8'hfe, 0}, '{OP_RR, 8'h40, 8'h00, 0, 1, 0, 1, 8'hbf, 0},
		'{OP_RLC, 8'h40, 8'h00, 0, 1, 0, 1, 8'hff, 0}, '{OP_RRC, 8'h40, 8'h00, 0, 1, 0, 1, 8'h3f, 0},
		'{OP_CPL, 8'h40, 8'h00, 0, 1, 0, 1, 8'h80, 0}, '{OP_LOADI, 8'h00, 8'hf0, 1, 1, 0, 1, 8'hf0, 0},
		'{OP_AND, 8'h00, 8'h3c, 1, 1, 0, 1, 8'h30, 0}, '{OP_OR, 8'h00, 8'h0f, 1, 1, 0, 1, 8'h3f, 0},
		'{OP_XOR, 8'h00, 8'hff, 1, 1, 0, 1, 8'hc0, 0}, '{OP_LOADI, 8'h00, 8'h05, 1, 1, 0, 1, 8'h05, 0},
		'{OP_ADD, 8'h00, 8'h05, 1, 1, 0, 1, 8'h0a, 0}, '{OP_DAA, 8'h05, 8'h00, 0, 1, 0, 1, 8'h10, 0},
		'{OP_LOADI, 8'h00, 8'h41, 1, 1, 0, 1, 8'h41, 0}, '{OP_WRITE, 8'h01, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_LOADI, 8'h00, 8'h5a, 1, 1, 0, 1, 8'h5a, 0}, '{OP_WRITE, 8'h00, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_READ, 8'h41, 8'h00, 0, 0, 0, 1, 8'h5a, 0}, '{OP_READ, 8'h00, 8'h00, 0, 0, 0, 1, 8'h5a, 0},
		'{OP_LOADI, 8'h00, 8'h02, 1, 1, 0, 1, 8'h02, 0}, '{OP_WRITE, 8'h03, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_READ, 8'h02, 8'h00, 0, 0, 0, 1, 8'h00, 0}, '{OP_LOADI, 8'h00, 8'haa, 1, 1, 0, 1, 8'haa, 0},
		'{OP_WRITE, 8'h2b, 8'h00, 0, 0, 0, 0, 8'h00, 0}, '{OP_READ, 8'h2b, 8'h00, 0, 0, 0, 1, 8'h00, 0},
		'{OP_SZ, 8'h2b, 8'h00, 0, 0, 0, 0, 8'h00, 1}, '{OP_SZ, 8'h40, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_SNZB, 8'h40, 8'h00, 0, 0, 0, 0, 8'h00, 1}, '{OP_SNZB, 8'h40, 8'h00, 0, 0, 7, 0, 8'h00, 0},
		'{OP_LOADI, 8'h00, 8'h01, 1, 1, 0, 1, 8'h01, 0}, '{OP_WRITE, 8'h43, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_SDZ, 8'h43, 8'h00, 0, 0, 0, 0, 8'h00, 1}, '{OP_SIZ, 8'h40, 8'h00, 0, 0, 0, 0, 8'h00, 0},
		'{OP_SETB, 8'h44, 8'h00, 0, 0, 7, 0, 8'h00, 0}, '{OP_READ, 8'h44, 8'h00, 0, 0, 0, 1, 8'h80, 0},
		'{OP_CLRB, 8'h44, 8'h00, 0, 0, 7, 0, 8'h00, 0}};

	always #12.5 clk_i = ~clk_i;

	mssd_core mssd_core_inst (.clk_i, .rst_n_i, .exec_valid_i, .op_i, .addr_i, .imm_i, .use_imm_i, .to_acc_i,
		.bit_i, .data_bank_i, .call_i, .return_from_sub_i, .return_from_irq_i, .pc_i, .halt_i,
		.watchdog_clear_instr_i, .watchdog_timeout_i, .timer0_ovf_i, .timer1_ovf_i, .rdata_o, .skip_o,
		.ret_pc_o, .irq_ack_o, .irq_vec_o, .working_accumulator_o);
	mssd_seq_model mssd_seq_model_inst (.clk_i, .rst_n_i, .load_i(load_q), .load_pc_i(load_pc_q),
		.irq_ack_i(irq_ack_o), .irq_vec_i(irq_vec_o), .pc_o(pc_i));

	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic rst();
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
	endtask

	task automatic ex(input mssd_op_t op, input logic [7:0] a, input logic [7:0] im, input logic ui,
		input logic ta, input logic [2:0] b);
		@(posedge clk_i);
		exec_valid_i <= 1'b1;
		op_i <= op;
		addr_i <= a;
		imm_i <= im;
		use_imm_i <= ui;
		to_acc_i <= ta;
		bit_i <= b;
		@(posedge clk_i);
		exec_valid_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		ex(OP_READ, a, 8'h00, 1'b0, 1'b0, 3'h0);
		chk({5'h00, rdata_o}, {5'h00, e});
	endtask

	// Bit order of k is call, plain return, return from interrupt; a call also jumps to pc.
	task automatic ctl(input logic [2:0] k, input logic [12:0] pc);
		@(posedge clk_i);
		{call_i, return_from_sub_i, return_from_irq_i} <= k;
		load_q <= k[2];
		load_pc_q <= pc;
		@(posedge clk_i);
		{call_i, return_from_sub_i, return_from_irq_i} <= 3'b000;
		load_q <= 1'b0;
		#1;
	endtask

	// Bit order of e is halt, watchdog clear, watchdog expiry, timer 0, timer 1.
	task automatic evt(input logic [4:0] e);
		@(posedge clk_i);
		{halt_i, watchdog_clear_instr_i, watchdog_timeout_i, timer0_ovf_i, timer1_ovf_i} <= e;
		@(posedge clk_i);
		{halt_i, watchdog_clear_instr_i, watchdog_timeout_i, timer0_ovf_i, timer1_ovf_i} <= 5'h00;
		#1;
	endtask

	task automatic noack(input int n);
		repeat (n) begin
			@(posedge clk_i);
			#1;
			chk({12'h000, irq_ack_o}, 13'h0000);
		end
	endtask

	task automatic wack(input logic [12:0] v);
		for (int i = 0; i < 8 && irq_ack_o !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk({12'h000, irq_ack_o}, 13'h0001);
		if (irq_ack_o !== 1'b1) summarize();
		chk(irq_vec_o, v);
	endtask

	initial begin
		rst();
		chk({5'h00, working_accumulator_o}, 13'h0000);
		chk(ret_pc_o, 13'h0000);
		foreach (rows[i]) begin
			ex(rows[i].op, rows[i].a, rows[i].im, rows[i].ui, rows[i].ta, rows[i].b);
			if (rows[i].ck === 1'b1) chk({5'h00, rdata_o}, {5'h00, rows[i].ex});
			chk({12'h000, skip_o}, {12'h000, rows[i].sk});
		end
		rd(8'h44, 8'h00);
		$display("test table done");
		data_bank_i <= 1'b1;
		ex(OP_LOADI, 8'h00, 8'h77, 1'b1, 1'b1, 3'h0);
		ex(OP_WRITE, 8'hff, 8'h00, 1'b0, 1'b0, 3'h0);
		data_bank_i <= 1'b0;
		rd(8'hff, 8'h00);
		data_bank_i <= 1'b1;
		rd(8'hff, 8'h77);
		data_bank_i <= 1'b0;
		$display("test banks done");
		for (int i = 1; i <= 9; i++) ctl(3'b100, 13'(i));
		ex(OP_LOADI, 8'h00, 8'h05, 1'b1, 1'b1, 3'h0);
		ex(OP_WRITE, ADDR_IRQ, 8'h00, 1'b0, 1'b0, 3'h0);
		evt(5'h02);
		noack(4);
		rd(ADDR_IRQ, 8'h25);
		ctl(3'b010, 13'h0000);
		chk(ret_pc_o, 13'h0009);
		wack(VEC_TIMER0);
		rd(ADDR_IRQ, 8'h04);
		evt(5'h03);
		noack(4);
		rd(ADDR_IRQ, 8'h64);
		ctl(3'b001, 13'h0000);
		chk(ret_pc_o, 13'h0009);
		wack(VEC_TIMER0);
		rd(ADDR_IRQ, 8'h44);
		ctl(3'b010, 13'h0000);
		chk(ret_pc_o, VEC_TIMER0);
		for (int i = 8; i >= 2; i--) begin
			ctl(3'b010, 13'h0000);
			chk(ret_pc_o, 13'(i));
		end
		rd(ADDR_IRQ, 8'h44);
		ex(OP_LOADI, 8'h00, 8'h4d, 1'b1, 1'b1, 3'h0);
		ex(OP_WRITE, ADDR_IRQ, 8'h00, 1'b0, 1'b0, 3'h0);
		wack(VEC_TIMER1);
		$display("test stack done");
		rst();
		chk(ret_pc_o, 13'h0000);
		chk(irq_vec_o, 13'h0000);
		evt(5'h10);
		rd(ADDR_FLAGS, 8'h10);
		evt(5'h04);
		rd(ADDR_FLAGS, 8'h30);
		ex(OP_LOADI, 8'h00, 8'hff, 1'b1, 1'b1, 3'h0);
		ex(OP_WRITE, ADDR_FLAGS, 8'h00, 1'b0, 1'b0, 3'h0);
		rd(ADDR_FLAGS, 8'h3f);
		ex(OP_LOADI, 8'h00, 8'h00, 1'b1, 1'b1, 3'h0);
		ex(OP_WRITE, ADDR_FLAGS, 8'h00, 1'b0, 1'b0, 3'h0);
		rd(ADDR_FLAGS, 8'h30);
		evt(5'h08);
		rd(ADDR_FLAGS, 8'h00);
		evt(5'h04);
		evt(5'h10);
		rd(ADDR_FLAGS, 8'h10);
		ex(OP_READ, ADDR_FLAGS, 8'h00, 1'b0, 1'b1, 3'h0);
		ex(OP_WRITE, 8'h50, 8'h00, 1'b0, 1'b0, 3'h0);
		@(posedge clk_i);
		call_i <= 1'b1;
		load_q <= 1'b1;
		load_pc_q <= 13'h0123;
		@(posedge clk_i);
		call_i <= 1'b0;
		load_q <= 1'b0;
		return_from_sub_i <= 1'b1;
		@(posedge clk_i);
		return_from_sub_i <= 1'b0;
		#1;
		chk(ret_pc_o, 13'h0123);
		ex(OP_ADD, 8'h00, 8'hff, 1'b1, 1'b1, 3'h0);
		rd(ADDR_FLAGS, 8'h11);
		ex(OP_READ, 8'h50, 8'h00, 1'b0, 1'b1, 3'h0);
		ex(OP_WRITE, ADDR_FLAGS, 8'h00, 1'b0, 1'b0, 3'h0);
		rd(ADDR_FLAGS, 8'h10);
		$display("test flags done");
		summarize();
	end
endmodule
